// ===== rtl/sto_pkg.sv
// Constants shared by the safe torque off interlock and its input filter.
// Assumes a single 10 MHz control clock.
package sto_pkg;

    // =========================================================
    // Timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned STOP_MS         = 20;
    localparam int unsigned FILTER_US       = 1000;
    localparam int unsigned DISC_US         = 2000;
    localparam int unsigned STOP_CYCLES_DEF = STOP_MS * (CLK_HZ / 1000);
    localparam int unsigned FILT_CYCLES_DEF =
        (FILTER_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned DISC_CYCLES_DEF =
        (DISC_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned CNT_W           = 24;

    // =========================================================
    // Fault log codes
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_CH1_ERR = 8'h48;
    localparam logic [7:0] CODE_STO     = 8'h4C;
    localparam logic [7:0] CODE_CH2_ERR = 8'h4D;
    localparam logic [7:0] CODE_INT_ERR = 8'h4E;

    // =========================================================
    // Interlock states
    typedef enum logic [2:0] {
        ST_INIT     = 3'b000,
        ST_READY    = 3'b001,
        ST_WAIT_RUN = 3'b010,
        ST_DISC     = 3'b011,
        ST_STO      = 3'b100,
        ST_CH1_ERR  = 3'b101,
        ST_CH2_ERR  = 3'b110,
        ST_INT_ERR  = 3'b111
    } mode_t;

endpackage

// ===== rtl/channel_filter.sv
// Two-flop synchroniser and glitch filter for one safety channel pin.
// Assumes the pin is asynchronous to clk and active high (on).
`timescale 1ns/100ps
module channel_filter #(
    parameter int unsigned FILT_CYCLES = sto_pkg::FILT_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    // Pin side
    input  wire logic pin_in,
    // Filtered side
    output logic      level_out,
    output logic      settled_out,
    output logic      sync_out
);
    import sto_pkg::*;

    typedef struct packed {
        logic             meta;
        logic             sync;
        logic             level;
        logic             settled;
        logic [CNT_W-1:0] cnt;
    } filt_t;

    filt_t s_ff;
    filt_t nxt_s;

    // =========================================================
    // Filter: once settled, level follows only after a stable run of samples; the first level after reset is one sample
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.meta = pin_in;
        nxt_s.sync = s_ff.meta;
        if (s_ff.sync == s_ff.level && s_ff.settled) begin
            nxt_s.cnt = '0;
        end else if (s_ff.cnt == CNT_W'(FILT_CYCLES - 1)) begin
            nxt_s.level   = s_ff.sync;
            nxt_s.settled = 1'b1;
            nxt_s.cnt     = '0;
        end else begin
            nxt_s.cnt = s_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    assign level_out   = s_ff.level;
    assign settled_out = s_ff.settled;
    assign sync_out    = s_ff.sync;

endmodule

// ===== rtl/safe_torque_off_interlock.sv
// Dual-channel safe torque off interlock: classifies the two safety
// channels, gates torque output and logs faults.
// Assumes run and reset commands and self-check faults come from clk logic.
`timescale 1ns/100ps
// Functional notes
// - With both channels on, torque follows the run command, no error.
// - Both channels off together gives the safe torque off state and alarm.
// - Channel one off with channel two on gives the channel-one loop error.
// - Channel two off with channel one on gives the channel-two loop error.
// - A self-check fault in either channel gives the internal loop error.
// - Torque is fully off within 20 ms of a channel going off.
// - Latch select zero holds the torque off alarm until a reset command.
// - Latch select one clears the torque off alarm once both channels are on.
// - The three loop errors always latch, whatever the latch select.
// - Faults are logged with codes 72, 76, 77 and 78.
// - A loop error clears only by power cycling, never by reset or inputs.
// - After an automatic clear, output resumes only after run is re-pressed.
// - With restart selected, a still-present run resumes at once on reset.
module safe_torque_off_interlock #(
    parameter int unsigned FILT_CYCLES = sto_pkg::FILT_CYCLES_DEF,
    parameter int unsigned DISC_CYCLES = sto_pkg::DISC_CYCLES_DEF,
    parameter int unsigned STOP_CYCLES = sto_pkg::STOP_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire logic           clk_en,
    // Safety channel pins
    input  wire logic           safety_channel_one_in,
    input  wire logic           safety_channel_two_in,
    // Self-check faults per channel
    input  wire logic [1:0]     internal_fault_in,
    // Commands and configuration
    input  wire logic           run_cmd,
    input  wire logic           reset_cmd,
    input  wire logic           alarm_latch_select,
    input  wire logic           restart_after_reset_select,
    // Drive and status
    output logic                torque_enable,
    output sto_pkg::mode_t      safety_state,
    output logic                alarm_active,
    output logic [7:0]          fault_code,
    output logic                fault_log_valid
);
    import sto_pkg::*;

    typedef struct packed {
        mode_t            mode;
        logic [CNT_W-1:0] cnt;
        logic             torque;
        logic [7:0]       code;
        logic             log_vld;
    } ilk_t;

    ilk_t s_ff;
    ilk_t nxt_s;

    logic [1:0] pin_vec;
    logic [1:0] lvl;
    logic [1:0] settled;
    logic [1:0] sync_lvl;
    logic       ch1_on;
    logic       ch2_on;
    logic       both_on;
    logic       both_off;
    logic       int_fault;

    assign pin_vec = {safety_channel_two_in, safety_channel_one_in};

    // =========================================================
    // Channel filters
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            channel_filter #(
                .FILT_CYCLES (FILT_CYCLES)
            ) u_filt (
                .clk         (clk),
                .rstn        (rstn),
                .clk_en      (clk_en),
                .pin_in      (pin_vec[gi]),
                .level_out   (lvl[gi]),
                .settled_out (settled[gi]),
                .sync_out    (sync_lvl[gi])
            );
        end
    endgenerate

    assign ch1_on    = lvl[0];
    assign ch2_on    = lvl[1];
    assign both_on   = ch1_on && ch2_on;
    assign both_off  = !ch1_on && !ch2_on;
    assign int_fault = |internal_fault_in;

    // =========================================================
    // Interlock state machine
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.log_vld = 1'b0;
        if (int_fault && s_ff.mode != ST_INT_ERR) begin
            nxt_s.mode    = ST_INT_ERR;
            nxt_s.code    = CODE_INT_ERR;
            nxt_s.log_vld = 1'b1;
        end else begin
            case (s_ff.mode)
                ST_INIT: begin
                    if (&settled) begin
                        nxt_s.mode = ST_WAIT_RUN;
                    end
                end
                ST_READY, ST_WAIT_RUN: begin
                    if (both_off) begin
                        nxt_s.mode    = ST_STO;
                        nxt_s.code    = CODE_STO;
                        nxt_s.log_vld = 1'b1;
                    end else if (!both_on) begin
                        nxt_s.mode = ST_DISC;
                        nxt_s.cnt  = '0;
                    end else if (s_ff.mode == ST_WAIT_RUN && !run_cmd) begin
                        nxt_s.mode = ST_READY;
                    end
                end
                ST_DISC: begin
                    // Skew between channels resolves before a verdict
                    if (both_off) begin
                        nxt_s.mode    = ST_STO;
                        nxt_s.code    = CODE_STO;
                        nxt_s.log_vld = 1'b1;
                    end else if (both_on) begin
                        nxt_s.mode = ST_WAIT_RUN;
                    end else if (s_ff.cnt == CNT_W'(DISC_CYCLES - 1)) begin
                        nxt_s.log_vld = 1'b1;
                        if (!ch1_on) begin
                            nxt_s.mode = ST_CH1_ERR;
                            nxt_s.code = CODE_CH1_ERR;
                        end else begin
                            nxt_s.mode = ST_CH2_ERR;
                            nxt_s.code = CODE_CH2_ERR;
                        end
                    end else begin
                        nxt_s.cnt = s_ff.cnt + CNT_W'(1);
                    end
                end
                ST_STO: begin
                    if (alarm_latch_select) begin
                        if (both_on) begin
                            nxt_s.mode = ST_WAIT_RUN;
                        end
                    end else if (reset_cmd && both_on) begin
                        // Held otherwise until reset
                        nxt_s.mode = restart_after_reset_select ?
                                     ST_READY : ST_WAIT_RUN;
                    end
                end
                ST_CH1_ERR, ST_CH2_ERR, ST_INT_ERR: begin
                    nxt_s.mode = s_ff.mode;
                end
                default: begin
                    nxt_s.mode = ST_INT_ERR;
                end
            endcase
        end
        // Torque only in ready with both channels on
        nxt_s.torque = (nxt_s.mode == ST_READY) && both_on && run_cmd;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '{mode: ST_INIT, cnt: '0, torque: 1'b0,
                      code: CODE_NONE, log_vld: 1'b0};
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    assign torque_enable   = s_ff.torque;
    assign safety_state    = s_ff.mode;
    assign alarm_active    = s_ff.mode[2];
    assign fault_code      = s_ff.code;
    assign fault_log_valid = s_ff.log_vld;

    // =========================================================
    // Assertions
    logic [CNT_W-1:0] resp_cnt;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resp_cnt <= '0;
        end else if (torque_enable && !(&sync_lvl)) begin
            resp_cnt <= resp_cnt + CNT_W'(1);
        end else begin
            resp_cnt <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ready_runs: assert property (
        clk_en && s_ff.mode == ST_READY && both_on && run_cmd && !int_fault
        |=> torque_enable)
        else $error("torque not enabled in ready with run");
    a_both_off_sto: assert property (
        clk_en && (s_ff.mode == ST_READY || s_ff.mode == ST_WAIT_RUN)
        && both_off && !int_fault
        |=> s_ff.mode == ST_STO && !torque_enable && fault_log_valid)
        else $error("both channels off did not give torque off state");
    a_ch1_error: assert property (
        clk_en && s_ff.mode == ST_DISC && !ch1_on && ch2_on && !int_fault
        && s_ff.cnt == CNT_W'(DISC_CYCLES - 1)
        |=> s_ff.mode == ST_CH1_ERR && !torque_enable)
        else $error("channel one error not entered");
    a_ch2_error: assert property (
        clk_en && s_ff.mode == ST_DISC && ch1_on && !ch2_on && !int_fault
        && s_ff.cnt == CNT_W'(DISC_CYCLES - 1)
        |=> s_ff.mode == ST_CH2_ERR && !torque_enable)
        else $error("channel two error not entered");
    a_internal_err: assert property (
        clk_en && int_fault && s_ff.mode != ST_INT_ERR
        |=> s_ff.mode == ST_INT_ERR && !torque_enable)
        else $error("internal fault did not give internal error");
    a_stop_time: assert property (
        resp_cnt < CNT_W'(STOP_CYCLES))
        else $error("torque still on past stop response time");
    a_latch_hold: assert property (
        clk_en && s_ff.mode == ST_STO && !alarm_latch_select && !reset_cmd
        && !int_fault |=> s_ff.mode == ST_STO)
        else $error("latched alarm cleared without reset");
    a_auto_clear: assert property (
        clk_en && s_ff.mode == ST_STO && alarm_latch_select && both_on
        && !int_fault |=> s_ff.mode == ST_WAIT_RUN)
        else $error("unlatched alarm did not clear");
    a_loop_sticky: assert property (
        (s_ff.mode == ST_CH1_ERR || s_ff.mode == ST_CH2_ERR) && !int_fault
        |=> $stable(s_ff.mode) && !torque_enable)
        else $error("loop error left its state");
    a_log_codes: assert property (
        fault_log_valid |-> fault_code == 8'h48 || fault_code == 8'h4C
        || fault_code == 8'h4D || fault_code == 8'h4E)
        else $error("bad fault log code");
    a_internal_sticky: assert property (
        s_ff.mode == ST_INT_ERR |=> s_ff.mode == ST_INT_ERR [*2])
        else $error("internal error left its state");
    a_wait_release: assert property (
        s_ff.mode == ST_WAIT_RUN && run_cmd |=> !torque_enable)
        else $error("output resumed without run release");
    a_restart_run: assert property (
        clk_en && s_ff.mode == ST_STO && !alarm_latch_select && reset_cmd
        && both_on && restart_after_reset_select && !int_fault
        |=> s_ff.mode == ST_READY)
        else $error("restart after reset not taken");

    c_sto_entry: cover property (
        s_ff.mode == ST_READY ##1 s_ff.mode == ST_STO);
    c_ch1_entry: cover property (
        s_ff.mode == ST_DISC ##1 s_ff.mode == ST_CH1_ERR);
    c_skew_recover: cover property (
        s_ff.mode == ST_DISC ##1 s_ff.mode == ST_WAIT_RUN);
    c_auto_clear: cover property (
        s_ff.mode == ST_STO ##1 s_ff.mode == ST_WAIT_RUN
        ##[1:50] s_ff.mode == ST_READY);

endmodule

// ===== tb/estop_loop_model.sv
// Emergency stop switch loop feeding the two safety channel pins.
// Assumes an open contact lets the pin fall to its pulled-down off level.
`timescale 1ns/100ps
module estop_loop_model (
    // Bench commands
    input  wire logic press_both,
    input  wire logic open_one,
    input  wire logic open_two,
    // Channel pins
    output logic      ch_one,
    output logic      ch_two
);
    // =========================================================
    // Contacts
    assign ch_one = !(press_both || open_one);
    assign ch_two = !(press_both || open_two);
endmodule

// ===== tb/tb_safe_torque_off_interlock.sv
// Self-checking bench for the safe torque off interlock.
// Assumes short filter and discrepancy counts set through parameters.
`timescale 1ns/100ps
module tb_safe_torque_off_interlock;
    import sto_pkg::*;
    localparam int FILT_C = 4;
    localparam int DISC_C = 12;
    localparam int STOP_C = 20;
    localparam int LIMIT  = 6000;

    // =========================================================
    // Signals
    logic       clk = 0, rstn = 0, run_cmd = 0, reset_cmd = 0;
    logic       latch_sel = 0, restart_sel = 0, clk_en = 1;
    logic [1:0] internal_fault = 2'b00;
    logic       press_both = 0, open_one = 0, open_two = 0;
    wire        ch_one, ch_two;
    logic       torque_enable, alarm_active, fault_log_valid;
    logic [7:0] fault_code;
    mode_t      safety_state;
    int         n_fail = 0, samples_checked = 0, cycles = 0;
    int         n_log = 0, log_mark = 0;

    estop_loop_model loop (
        .press_both (press_both),
        .open_one   (open_one),
        .open_two   (open_two),
        .ch_one     (ch_one),
        .ch_two     (ch_two)
    );

    safe_torque_off_interlock #(
        .FILT_CYCLES (FILT_C),
        .DISC_CYCLES (DISC_C),
        .STOP_CYCLES (STOP_C)
    ) DUT (
        .clk                        (clk),
        .rstn                       (rstn),
        .clk_en                     (clk_en),
        .safety_channel_one_in      (ch_one),
        .safety_channel_two_in      (ch_two),
        .internal_fault_in          (internal_fault),
        .run_cmd                    (run_cmd),
        .reset_cmd                  (reset_cmd),
        .alarm_latch_select         (latch_sel),
        .restart_after_reset_select (restart_sel),
        .torque_enable              (torque_enable),
        .safety_state               (safety_state),
        .alarm_active               (alarm_active),
        .fault_code                 (fault_code),
        .fault_log_valid            (fault_log_valid)
    );

    // =========================================================
    // Clock, timeout, log pulse monitor
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            n_fail++;
            end_sim();
        end
    end
    always @(negedge clk) begin
        if (fault_log_valid === 1'b1)
            n_log++;
    end

    // =========================================================
    // Helpers
    task end_sim();
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task chk_val(input string what, input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task chk_state(input mode_t exp);
        samples_checked++;
        if (safety_state !== exp) begin
            n_fail++;
            $display("ERROR %0t state %0d exp %0d", $time, safety_state, exp);
        end
    endtask
    task wait_state(input mode_t exp, input int maxc);
        for (int i = 0; i < maxc && safety_state !== exp; i++)
            cyc(1);
        chk_state(exp);
    endtask
    task pulse_reset();
        reset_cmd = 1;
        cyc(1);
        reset_cmd = 0;
        cyc(2);
    endtask
    task start_run();
        run_cmd = 1;
        cyc(2);
        chk_val("torque on", {7'h00, torque_enable}, 8'h01);
    endtask
    task stop_within();
        for (int i = 0; i < STOP_C && torque_enable !== 1'b0; i++)
            cyc(1);
        chk_val("torque off", {7'h00, torque_enable}, 8'h00);
    endtask
    task chk_fault(input logic [7:0] code);
        // One cycle on, so the negedge monitor has seen the pulse
        cyc(1);
        chk_val("code", fault_code, code);
        chk_val("log", 8'(n_log - log_mark), 8'h01);
        chk_val("alarm", {7'h00, alarm_active}, 8'h01);
        log_mark = n_log;
    endtask

    // =========================================================
    // Scenarios
    task power_up();
        {rstn, run_cmd, press_both, open_one, open_two} = 5'h00;
        internal_fault = 2'b00;
        cyc(3);
        chk_state(ST_INIT);
        chk_val("code rst", fault_code, 8'h00);
        chk_val("torque rst", {7'h00, torque_enable}, 8'h00);
        chk_val("alarm rst", {7'h00, alarm_active}, 8'h00);
        rstn = 1;
        wait_state(ST_WAIT_RUN, 20);
        wait_state(ST_READY, 3);
        log_mark = n_log;
    endtask
    task t_normal();
        start_run();
        chk_val("no alarm", {7'h00, alarm_active}, 8'h00);
        run_cmd = 0;
        cyc(2);
        chk_val("run stop", {7'h00, torque_enable}, 8'h00);
        chk_state(ST_READY);
    endtask
    task t_freeze();
        clk_en = 0;
        run_cmd = 1;
        cyc(3);
        chk_val("frozen", {7'h00, torque_enable}, 8'h00);
        clk_en = 1;
        cyc(2);
        chk_val("thawed", {7'h00, torque_enable}, 8'h01);
        run_cmd = 0;
        cyc(2);
    endtask
    task t_skew();
        start_run();
        open_one = 1;
        cyc(FILT_C + 3);
        chk_state(ST_DISC);
        chk_val("skew off", {7'h00, torque_enable}, 8'h00);
        open_one = 0;
        wait_state(ST_WAIT_RUN, FILT_C + 4);
        chk_val("skew log", 8'(n_log - log_mark), 8'h00);
        run_cmd = 0;
        wait_state(ST_READY, 3);
        open_one = 1;
        cyc(2);
        open_two = 1;
        wait_state(ST_STO, FILT_C + 8);
        chk_fault(8'h4C);
        {open_one, open_two} = 2'b00;
        cyc(FILT_C + 4);
        pulse_reset();
        wait_state(ST_READY, 3);
    endtask
    task t_sto_latched();
        start_run();
        press_both = 1;
        stop_within();
        wait_state(ST_STO, 4);
        chk_fault(8'h4C);
        pulse_reset();
        chk_state(ST_STO);
        press_both = 0;
        cyc(FILT_C + 8);
        chk_state(ST_STO);
        pulse_reset();
        wait_state(ST_WAIT_RUN, 3);
        chk_val("no restart", {7'h00, torque_enable}, 8'h00);
        run_cmd = 0;
        wait_state(ST_READY, 3);
    endtask
    task t_sto_restart();
        restart_sel = 1;
        start_run();
        press_both = 1;
        wait_state(ST_STO, STOP_C);
        press_both = 0;
        cyc(FILT_C + 4);
        pulse_reset();
        chk_state(ST_READY);
        chk_val("restart", {7'h00, torque_enable}, 8'h01);
        restart_sel = 0;
        run_cmd = 0;
        cyc(2);
        log_mark = n_log;
    endtask
    task t_sto_auto();
        latch_sel = 1;
        start_run();
        press_both = 1;
        wait_state(ST_STO, STOP_C);
        press_both = 0;
        wait_state(ST_WAIT_RUN, FILT_C + 6);
        cyc(3);
        chk_val("held run", {7'h00, torque_enable}, 8'h00);
        run_cmd = 0;
        cyc(1);
        run_cmd = 1;
        wait_state(ST_READY, 3);
        cyc(2);
        chk_val("rerun", {7'h00, torque_enable}, 8'h01);
        latch_sel = 0;
        run_cmd = 0;
        cyc(2);
        log_mark = n_log;
    endtask
    task t_loop(input bit second);
        mode_t      err_st;
        logic [7:0] err_code;
        err_st   = second ? ST_CH2_ERR : ST_CH1_ERR;
        err_code = second ? 8'h4D : 8'h48;
        latch_sel = 1;
        start_run();
        if (second)
            open_two = 1;
        else
            open_one = 1;
        stop_within();
        wait_state(err_st, DISC_C + FILT_C + 8);
        chk_fault(err_code);
        {open_one, open_two} = 2'b00;
        cyc(FILT_C + 4);
        pulse_reset();
        chk_state(err_st);
        chk_val("loop off", {7'h00, torque_enable}, 8'h00);
        latch_sel = 0;
        power_up();
    endtask
    task t_internal();
        start_run();
        internal_fault = 2'b10;
        wait_state(ST_INT_ERR, 3);
        chk_val("int off", {7'h00, torque_enable}, 8'h00);
        chk_fault(8'h4E);
        internal_fault = 2'b00;
        pulse_reset();
        chk_state(ST_INT_ERR);
        power_up();
    endtask
    task t_glitch();
        start_run();
        open_one = 1;
        cyc(2);
        open_one = 0;
        cyc(FILT_C + 4);
        chk_state(ST_READY);
        chk_val("glitch", {7'h00, torque_enable}, 8'h01);
        run_cmd = 0;
        cyc(2);
    endtask

    // =========================================================
    // Main sequence
    initial begin
        power_up();
        t_normal();
        t_freeze();
        t_glitch();
        t_skew();
        t_sto_latched();
        t_sto_restart();
        t_sto_auto();
        t_loop(1'b0);
        t_loop(1'b1);
        t_internal();
        end_sim();
    end
endmodule
